// >>> hw/lalu_core.sv
// Sequencer and datapath for the long-addressed ALU operation subset.
module lalu_core (
  // Clock, reset and enable.
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         ce_i,
  // Operation request from the decoder.
  input  wire logic                         op_valid_i,
  input  wire logic [3:0]                   op_i,
  input  wire logic [lalu_pkg::LALU_AW-1:0] addr_i,
  output logic                              ready_o,
  output logic                              done_o,
  // Data memory port.
  output logic                              mem_rd_o,
  output logic                              mem_wr_o,
  output logic      [lalu_pkg::LALU_AW-1:0] mem_addr_o,
  output logic      [lalu_pkg::LALU_DW-1:0] mem_wdata_o,
  input  wire logic [lalu_pkg::LALU_DW-1:0] mem_rdata_i,
  // Work register and status flags.
  output logic      [lalu_pkg::LALU_DW-1:0] work_o,
  output logic                              null_flag_o,
  output logic                              ovf_bit_o
);
  import lalu_pkg::*;

  // ****************************************
  // State
  // ****************************************
  lalu_state_e          state_ff;
  lalu_op_e             op_ff;
  logic [LALU_AW-1:0]   addr_ff;
  logic                 mem_rd_ff;
  logic                 mem_wr_ff;
  logic [LALU_DW-1:0]   wdata_ff;
  logic [LALU_DW-1:0]   work_ff;
  logic                 null_ff;
  logic                 ovf_ff;
  logic                 done_ff;
  logic                 ready_ff;
  logic [LALU_DW-1:0]   nxt_res;
  logic                 nxt_to_mem;
  logic                 nxt_to_work;
  logic                 nxt_null_upd;
  logic                 nxt_ovf_upd;
  logic [LALU_DW-1:0]   rol_res;
  logic                 rol_out;
  logic [LALU_DW-1:0]   ror_res;
  logic                 rol_fill;
  logic                 take;
  logic                 calc;

  assign take = ce_i && ready_ff && op_valid_i;
  assign calc = ce_i && (state_ff == LALU_ST_CALC);

  // ****************************************
  // Rotators
  // ****************************************
  // Through-overflow rotates fill from the old overflow bit, plain left ones from bit 7.
  assign rol_fill = ((op_ff == LALU_OP_RLC_MEM) || (op_ff == LALU_OP_RLC_WORK)) ?
                    ovf_ff : mem_rdata_i[7];

  lalu_rot #(.LEFT(1'b1)) u_rol (
    .data_i (mem_rdata_i),
    .fill_i (rol_fill),
    .res_o  (rol_res),
    .out_o  (rol_out)
  );

  lalu_rot #(.LEFT(1'b0)) u_ror (
    .data_i (mem_rdata_i),
    .fill_i (mem_rdata_i[0]),
    .res_o  (ror_res),
    .out_o  ()
  );

  // ****************************************
  // Operation decode
  // ****************************************
  // Selects the result of the operation held in op_ff.
  always_comb
  begin
    nxt_res = mem_rdata_i;
    case (op_ff)
      LALU_OP_DEC_WORK: nxt_res = mem_rdata_i - LALU_ONE;
      LALU_OP_INC_MEM, LALU_OP_INC_WORK: nxt_res = mem_rdata_i + LALU_ONE;
      LALU_OP_MOV_MEM: nxt_res = work_ff;
      LALU_OP_OR_WORK, LALU_OP_OR_MEM: nxt_res = work_ff | mem_rdata_i;
      LALU_OP_RL_MEM, LALU_OP_RL_WORK: nxt_res = rol_res;
      LALU_OP_RLC_MEM, LALU_OP_RLC_WORK: nxt_res = rol_res;
      LALU_OP_RR_MEM: nxt_res = ror_res;
      // copy byte to work; unknown codes leave the byte unused.
      default: nxt_res = mem_rdata_i;
    endcase
  end

  assign nxt_to_mem   = op_ff inside {LALU_OP_INC_MEM, LALU_OP_MOV_MEM, LALU_OP_OR_MEM,
                                      LALU_OP_RL_MEM, LALU_OP_RLC_MEM, LALU_OP_RR_MEM};
  assign nxt_to_work  = op_ff inside {LALU_OP_DEC_WORK, LALU_OP_INC_WORK, LALU_OP_MOV_WORK,
                                      LALU_OP_OR_WORK, LALU_OP_RL_WORK, LALU_OP_RLC_WORK};
  // zero test for increment, decrement and OR only
  assign nxt_null_upd = op_ff inside {LALU_OP_DEC_WORK, LALU_OP_INC_MEM, LALU_OP_INC_WORK,
                                      LALU_OP_OR_WORK, LALU_OP_OR_MEM};
  assign nxt_ovf_upd  = (op_ff == LALU_OP_RLC_MEM) || (op_ff == LALU_OP_RLC_WORK);

  // ****************************************
  // Sequencer
  // ****************************************
  // Walks idle, read, calculate, done; requests are only taken while idle.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= LALU_ST_IDLE;
      ready_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      unique case (state_ff)
        LALU_ST_IDLE: state_ff <= op_valid_i && ready_ff ? LALU_ST_READ : LALU_ST_IDLE;
        LALU_ST_READ: state_ff <= LALU_ST_CALC;
        LALU_ST_CALC: state_ff <= LALU_ST_DONE;
        LALU_ST_DONE: state_ff <= LALU_ST_IDLE;
      endcase
      ready_ff <= (state_ff == LALU_ST_DONE) || ((state_ff == LALU_ST_IDLE) && !op_valid_i);
    end
  end

  // Captures the request and issues the one-cycle memory read.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      op_ff     <= LALU_OP_DEC_WORK;
      addr_ff   <= LALU_ADDR_RST;
      mem_rd_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      mem_rd_ff <= take;
      if (take)
      begin
        op_ff   <= lalu_op_e'(op_i);
        addr_ff <= addr_i;
      end
    end
  end

  // ****************************************
  // Results
  // ****************************************
  // Memory write-back and completion pulse, one cycle each.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_wr_ff <= 1'b0;
      wdata_ff  <= LALU_ZERO;
      done_ff   <= 1'b0;
    end
    else if (ce_i)
    begin
      mem_wr_ff <= calc && nxt_to_mem;
      done_ff   <= calc;
      if (calc && nxt_to_mem)
      begin
        wdata_ff <= nxt_res;
      end
    end
  end

  // Work register load.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      work_ff <= LALU_WORK_RST;
    end
    else if (calc && nxt_to_work)
    begin
      work_ff <= nxt_res;
    end
  end

  // Status flags; wrap of increment and decrement never touches overflow.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      null_ff <= LALU_NULL_RST;
      ovf_ff  <= LALU_OVF_RST;
    end
    else if (calc)
    begin
      if (nxt_null_upd)
      begin
        null_ff <= (nxt_res == LALU_ZERO);
      end
      if (nxt_ovf_upd)
      begin
        ovf_ff <= rol_out;
      end
    end
  end

  assign ready_o     = ready_ff;
  assign done_o      = done_ff;
  assign mem_rd_o    = mem_rd_ff;
  assign mem_wr_o    = mem_wr_ff;
  assign mem_addr_o  = addr_ff;
  assign mem_wdata_o = wdata_ff;
  assign work_o      = work_ff;
  assign null_flag_o = null_ff;
  assign ovf_bit_o   = ovf_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_dec_work: assert property (calc && op_ff == LALU_OP_DEC_WORK |=>
    work_ff == $past(mem_rdata_i) - LALU_ONE && !mem_wr_ff)
    else $error("Decrement result in work is wrong.");
  a_inc_mem: assert property (calc && op_ff == LALU_OP_INC_MEM |=>
    mem_wr_ff && wdata_ff == $past(mem_rdata_i) + LALU_ONE && $stable(work_ff))
    else $error("Increment write-back is wrong.");
  a_mov_work: assert property (calc && op_ff == LALU_OP_MOV_WORK |=>
    work_ff == $past(mem_rdata_i) && $stable(null_ff) && $stable(ovf_ff))
    else $error("Move to work changed a flag or value.");
  a_mov_mem: assert property (calc && op_ff == LALU_OP_MOV_MEM |=>
    mem_wr_ff && wdata_ff == work_ff && $stable(null_ff))
    else $error("Move to memory is wrong.");
  a_or_work: assert property (calc && op_ff == LALU_OP_OR_WORK |=>
    work_ff == ($past(work_ff) | $past(mem_rdata_i)) && !mem_wr_ff)
    else $error("OR into work is wrong.");
  a_rl_mem: assert property (calc && op_ff == LALU_OP_RL_MEM |=>
    wdata_ff == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])} && $stable(ovf_ff))
    else $error("Rotate left write-back is wrong.");
  a_rlc_work: assert property (calc && op_ff == LALU_OP_RLC_WORK |=>
    work_ff[0] == $past(ovf_ff) && ovf_ff == $past(mem_rdata_i[7]) && !mem_wr_ff)
    else $error("Rotate through overflow into work is wrong.");
  a_rr_mem: assert property (calc && op_ff == LALU_OP_RR_MEM |=>
    wdata_ff == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])})
    else $error("Rotate right write-back is wrong.");
  a_null_flag: assert property (calc && nxt_null_upd |=>
    null_flag_o == ($past(nxt_res) == LALU_ZERO) && $stable(ovf_ff))
    else $error("Null flag does not follow the result.");
  a_done_timing: assert property (take ##1 ce_i ##1 ce_i ##1 ce_i |-> done_o ##1 !done_o)
    else $error("Completion pulse is late or long.");

  c_inc_wrap: cover property (calc && op_ff == LALU_OP_INC_MEM && mem_rdata_i == 8'hff);
  c_dec_zero: cover property (calc && op_ff == LALU_OP_DEC_WORK && mem_rdata_i == 8'h01);
  c_rlc_carry: cover property (calc && op_ff == LALU_OP_RLC_MEM && ovf_ff);
  c_back_to_back: cover property (done_o ##1 take);

endmodule : lalu_core

// >>> hw/lalu_rot.sv
// One-position rotate of a byte with a selectable fill bit.
module lalu_rot #(
  parameter bit LEFT = 1'b1
) (
  // Operand.
  input  wire logic [7:0] data_i,
  input  wire logic       fill_i,
  // Result.
  output logic      [7:0] res_o,
  output logic            out_o
);

  // Left moves bit 7 out and fill into bit 0; right moves bit 0 out and fill into bit 7.
  always_comb
  begin
    if (LEFT)
    begin
      res_o = {data_i[6:0], fill_i};
      out_o = data_i[7];
    end
    else
    begin
      res_o = {fill_i, data_i[7:1]};
      out_o = data_i[0];
    end
  end

endmodule : lalu_rot

// >>> shared/lalu_pkg.sv
// Constants, operation codes and state codes for the long-address ALU subset.
package lalu_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned LALU_DW = 8;
  localparam int unsigned LALU_AW = 16;

  // ****************************************
  // Values after reset and arithmetic constants
  // ****************************************
  localparam logic [LALU_DW-1:0] LALU_WORK_RST = 8'h00;
  localparam logic [LALU_AW-1:0] LALU_ADDR_RST = 16'h0000;
  localparam logic               LALU_NULL_RST = 1'h0;
  localparam logic               LALU_OVF_RST  = 1'h0;
  localparam logic [LALU_DW-1:0] LALU_ONE      = 8'h01;
  localparam logic [LALU_DW-1:0] LALU_ZERO     = 8'h00;

  // ****************************************
  // Operation codes
  // ****************************************
  typedef enum logic [3:0] {
    LALU_OP_DEC_WORK  = 4'h0,
    LALU_OP_INC_MEM   = 4'h1,
    LALU_OP_INC_WORK  = 4'h2,
    LALU_OP_MOV_WORK  = 4'h3,
    LALU_OP_MOV_MEM   = 4'h4,
    LALU_OP_OR_WORK   = 4'h5,
    LALU_OP_OR_MEM    = 4'h6,
    LALU_OP_RL_MEM    = 4'h7,
    LALU_OP_RL_WORK   = 4'h8,
    LALU_OP_RLC_MEM   = 4'h9,
    LALU_OP_RLC_WORK  = 4'ha,
    LALU_OP_RR_MEM    = 4'hb
  } lalu_op_e;

  // ****************************************
  // Sequencer states, Gray coded along the path
  // ****************************************
  typedef enum logic [1:0] {
    LALU_ST_IDLE = 2'h0,
    LALU_ST_READ = 2'h1,
    LALU_ST_CALC = 2'h3,
    LALU_ST_DONE = 2'h2
  } lalu_state_e;

endpackage : lalu_pkg

// >>> tb/lalu_mem_model.sv
// Synchronous data memory model on the far side of the core's memory port.
module lalu_mem_model (
  // Clock.
  input  wire logic                         clk_i,
  // Memory port from the core.
  input  wire logic                         mem_rd_i,
  input  wire logic                         mem_wr_i,
  input  wire logic [lalu_pkg::LALU_AW-1:0] mem_addr_i,
  input  wire logic [lalu_pkg::LALU_DW-1:0] mem_wdata_i,
  output logic      [lalu_pkg::LALU_DW-1:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import lalu_pkg::*;

  logic [LALU_DW-1:0] mem_ff [0:255];
  logic [LALU_DW-1:0] rdata_ff;

  // Data is valid only in the cycle after a read strobe; otherwise it flips every cycle.
  always_ff @(posedge clk_i)
  begin
    if (mem_rd_i)
      rdata_ff <= mem_ff[mem_addr_i[7:0]];
    else
      rdata_ff <= ~rdata_ff;
  end

  // Writes land at the edge that samples the strobe; the bench preloads the array.
  always @(posedge clk_i)
  begin
    if (mem_wr_i)
      mem_ff[mem_addr_i[7:0]] <= mem_wdata_i;
  end

  assign mem_rdata_o = rdata_ff;
endmodule : lalu_mem_model

// >>> tb/test_long_addr_alu_ops_subset.sv
// Self-checking testbench for the long-address ALU core with a reference model.
module test_long_addr_alu_ops_subset;
  timeunit 1ns;
  timeprecision 1ps;
  import lalu_pkg::*;

  logic clk_i, rst_n_i, ce_i, op_valid_i, ready_o, done_o, mem_rd_o, mem_wr_o;
  logic null_flag_o, ovf_bit_o;
  logic [3:0] op_i;
  logic [LALU_AW-1:0] addr_i, mem_addr_o;
  logic [LALU_DW-1:0] mem_wdata_o, mem_rdata_i, work_o;
  int fail_count = 0;
  int tests_run = 0;
  int ref_mem [256];
  int ref_w, ref_z, ref_c, i;
  logic [11:0] dir_tab [17] = '{12'h001, 12'h000, 12'h1ff, 12'h27f, 12'h300, 12'h500,
    12'h4c3, 12'h6a5, 12'h781, 12'h881, 12'h980, 12'ha01, 12'hb01, 12'hc55, 12'hd55,
    12'he55, 12'hf55};

  // ****************************************
  // Design, memory, clock and watchdog
  // ****************************************
  lalu_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .op_valid_i(op_valid_i),
    .op_i(op_i), .addr_i(addr_i), .ready_o(ready_o), .done_o(done_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .work_o(work_o), .null_flag_o(null_flag_o),
    .ovf_bit_o(ovf_bit_o));
  lalu_mem_model mem_u (.clk_i(clk_i), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

  // The clock runs at 40 MHz.
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // A hang cuts the run short as a mismatch.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    final_report();
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // Holds reset ten cycles and checks the cleared outputs.
  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(16'({ready_o, null_flag_o, ovf_bit_o, work_o}), 16'h0000);
    rst_n_i <= 1'b1;
    ref_w = 0;
    ref_z = 0;
    ref_c = 0;
  endtask : do_reset

  task automatic set_mem(input logic [15:0] a, input logic [7:0] m);
    ref_mem[a[7:0]] = int'(m);
    mem_u.mem_ff[a[7:0]] = m;
  endtask : set_mem

  // Runs one operation through the handshake and compares with the model.
  task automatic do_op(input logic [3:0] op, input logic [15:0] a);
    int m, res, k;
    bit to_mem, to_work;
    m = ref_mem[a[7:0]];
    case (op)
      4'h0: res = (m + 255) & 255;
      4'h1, 4'h2: res = (m + 1) & 255;
      4'h3: res = m;
      4'h4: res = ref_w;
      4'h5, 4'h6: res = ref_w | m;
      4'h7, 4'h8: res = ((m << 1) | (m >> 7)) & 255;
      4'h9, 4'ha: res = ((m << 1) | ref_c) & 255;
      4'hb: res = (m >> 1) | ((m & 1) << 7);
      default: res = 0;
    endcase
    to_mem = op inside {4'h1, 4'h4, 4'h6, 4'h7, 4'h9, 4'hb};
    to_work = op inside {4'h0, 4'h2, 4'h3, 4'h5, 4'h8, 4'ha};
    if (op inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6})
      ref_z = (res == 0);
    if (op inside {4'h9, 4'ha})
      ref_c = m >> 7;
    if (to_mem)
      ref_mem[a[7:0]] = res;
    if (to_work)
      ref_w = res;
    k = 0;
    while (ready_o !== 1'b1 && k < 50)
    begin
      @(negedge clk_i);
      k++;
    end
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i <= op;
    addr_i <= a;
    do
    begin
      @(negedge clk_i);
      k++;
    end while (ready_o !== 1'b0 && k < 100);
    chk(16'(mem_rd_o), 16'h0001);
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    op_i <= 4'($urandom);
    addr_i <= 16'($urandom);
    while (done_o !== 1'b1 && k < 150)
    begin
      @(negedge clk_i);
      k++;
    end
    chk(16'(k < 150), 16'h0001);
    chk(mem_addr_o, a);
    chk(16'(mem_wr_o), 16'(to_mem));
    if (to_mem)
      chk(16'(mem_wdata_o), 16'(res));
    chk(16'(work_o), 16'(ref_w));
    chk(16'(null_flag_o), 16'(ref_z));
    chk(16'(ovf_bit_o), 16'(ref_c));
    @(negedge clk_i);
    chk(16'(mem_u.mem_ff[a[7:0]]), 16'(ref_mem[a[7:0]]));
    chk(16'({done_o, ready_o}), 16'h0001);
  endtask : do_op

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    op_valid_i = 1'b0;
    op_i = 4'h0;
    addr_i = 16'h0000;
    void'($urandom(54009));
    for (i = 0; i < 256; i++)
      set_mem(16'(i), 8'($urandom));
    do_reset();
    $display("test reset done");
    // Every code with wrap, zero and carry boundary values.
    for (i = 0; i < 17; i++)
    begin
      set_mem(16'h1000 + 16'(i), dir_tab[i][7:0]);
      do_op(dir_tab[i][11:8], 16'h1000 + 16'(i));
    end
    $display("test directed done");
    // A request held while the clock enable is low is not taken.
    @(posedge clk_i);
    ce_i <= 1'b0;
    op_valid_i <= 1'b1;
    repeat (5)
    begin
      @(negedge clk_i);
      chk(16'({ready_o, mem_rd_o, done_o}), 16'h0004);
    end
    @(posedge clk_i);
    ce_i <= 1'b1;
    op_valid_i <= 1'b0;
    do_op(4'h2, 16'h00fe);
    $display("test enable done");
    for (i = 0; i < 300; i++)
      do_op(4'($urandom), 16'($urandom));
    $display("test random done");
    // A second reset in mid-run clears the work register and flags.
    do_reset();
    do_op(4'h3, 16'h0042);
    do_op(4'ha, 16'h8042);
    $display("test rereset done");
    final_report();
  end
endmodule : test_long_addr_alu_ops_subset
